/* asq_sequencer.sv */
// acquisition scan sequencer: config memory walk, conversion timing, sample count, adc fifo
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module asq_sequencer
  import asq_pkg::*;
#(
  parameter int CFG_DEPTH  = 16,
  parameter int FIFO_DEPTH = 512
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire asq_bus_t    bus_in,
  output logic [15:0]      rd_data_out,
  input  wire logic [15:0] adc_data_in,
  input  wire logic        adc_done_in,
  input  wire logic        external_conversion_strobe_n_in,
  input  wire logic        external_trigger_n_in,
  input  wire logic        counter_one_output_n_in,
  output logic             conv_start_out,
  output logic [15:0]      active_config_out,
  output logic             acq_running_out,
  output logic             acq_request_out
);
  localparam int CP = $clog2(CFG_DEPTH);
  localparam int FP = $clog2(FIFO_DEPTH);
  localparam logic [CP-1:0] C_LAST = CP'(CFG_DEPTH - 1);
  localparam logic [FP:0]   F_FULL = (FP + 1)'(FIFO_DEPTH);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (CFG_DEPTH < 2 || (CFG_DEPTH & (CFG_DEPTH - 1)) != 0) begin : g_bad_cfg
    $error("CFG_DEPTH must be a power of two of at least 2");
  end
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_fifo
    $error("FIFO_DEPTH must be a power of two of at least 2");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    asq_phase_t  phase;
    asq_cmd_t    cmd;
    logic [15:0] si;
    logic [15:0] sci;
    logic [15:0] cnt_lo;
    logic [15:0] cnt_hi;
    logic [15:0] si_cnt;
    logic [15:0] sci_cnt;
    logic [31:0] remaining;
    logic        counting;
    logic [CP-1:0] cfg_wr;
    logic [CP-1:0] ptr;
    logic [FP-1:0] f_wr;
    logic [FP-1:0] f_rd;
    logic [FP:0]   f_cnt;
    logic        overflow;
    logic        overrun;
    logic        complete;
    logic        request;
    logic        busy;
    logic        ext_q;
    logic        trig_q;
    logic        c1_q;
    logic        conv;
    logic [15:0] cfg_word;
    logic [15:0] rd_data;
    logic        running;
  } asq_state_t;

  asq_state_t  s;
  asq_state_t  next_s;
  logic [15:0] cfg_mem [CFG_DEPTH];
  logic [15:0] fifo_mem [FIFO_DEPTH];

  // zero written as the load value stands for 65536 counts
  function automatic logic [15:0] interval_reload(input logic [15:0] v);
    return v - ASQ_ONE;
  endfunction

  // ----------------------------------------------------------------
  // decode and events
  // ----------------------------------------------------------------
  logic wr_hit;
  logic rd_hit;
  logic cfg_we;
  logic cfg_load;
  logic acq_clr;
  logic sw_start;
  logic ext_fall;
  logic trig_fall;
  logic c1_fall;
  logic scan_mode;
  logic conv_req;
  logic advance;
  logic wrap;
  logic start_run;
  logic finish;
  logic push;
  logic pop;
  logic push_ok;
  logic [15:0] cfg_first;
  logic [31:0] count_load;
  asq_status_t st;

  assign wr_hit    = bus_in.wr;
  assign rd_hit    = bus_in.rd;
  assign cfg_we    = wr_hit && bus_in.addr == ASQ_REG_CFG_WIN;
  assign cfg_load  = wr_hit && bus_in.addr == ASQ_REG_CFG_LOAD;
  assign acq_clr   = wr_hit && bus_in.addr == ASQ_REG_ACQ_CLR;
  assign sw_start  = wr_hit && bus_in.addr == ASQ_REG_START;
  assign ext_fall  = s.ext_q && !external_conversion_strobe_n_in;
  assign trig_fall = s.trig_q && !external_trigger_n_in;
  assign c1_fall   = s.c1_q && !counter_one_output_n_in;
  assign cfg_first = cfg_mem[0];
  assign scan_mode = s.cmd.scan_enable_bit && s.cmd.acquisition_enable_bit;
  // under external timing the interval counter is not consulted at all
  assign conv_req  = s.phase == ASQ_RUN &&
                     (s.cmd.ext_timing ? ext_fall : s.si_cnt == 16'h0000);
  assign advance   = scan_mode && s.phase != ASQ_IDLE &&
                     (s.cmd.scan_divide_bit ? c1_fall : conv_req);
  assign wrap      = advance && (cfg_mem[s.ptr][ASQ_EOL_BIT] || s.ptr == C_LAST);
  assign start_run = s.phase == ASQ_IDLE && s.cmd.acquisition_enable_bit &&
                     (sw_start || trig_fall);
  assign finish    = conv_req && s.counting && s.remaining == ASQ_LAST_COUNT;
  assign push      = adc_done_in && !acq_clr;
  assign push_ok   = push && s.f_cnt != F_FULL;
  assign pop       = rd_hit && bus_in.addr == ASQ_REG_FIFO && s.f_cnt != '0;
  // a 16-bit run treats a zero low half as the full 65536 count
  assign count_load = s.cmd.cascade_count_select ? {s.cnt_hi, s.cnt_lo} :
                      (s.cnt_lo == ASQ_COUNT_RESET ? ASQ_FULL_COUNT :
                       {16'h0000, s.cnt_lo});

  always_comb begin
    st = '0;
    st.overflow                  = s.overflow;
    st.overrun                   = s.overrun;
    st.acquisition_complete_flag = s.complete;
    st.adc_fifo_not_empty_flag   = s.f_cnt != '0;
    st.running                   = s.phase != ASQ_IDLE;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s         = s;
    next_s.conv    = 1'b0;
    next_s.rd_data = 16'h0000;
    next_s.ext_q   = external_conversion_strobe_n_in;
    next_s.trig_q  = external_trigger_n_in;
    next_s.c1_q    = counter_one_output_n_in;
    // register writes land here; of the strobes only the walk clear acts here, and none keeps the data
    if (wr_hit) begin
      case (bus_in.addr)
        ASQ_REG_CMD:     next_s.cmd = asq_cmd_t'(bus_in.data);
        ASQ_REG_CFG_WIN: next_s.cfg_wr = s.cfg_wr + 1'b1;
        ASQ_REG_CFG_CLR: next_s.cfg_wr = '0;
        ASQ_REG_SI:      next_s.si = bus_in.data;
        ASQ_REG_SCI:     next_s.sci = bus_in.data;
        ASQ_REG_CNT_LO:  next_s.cnt_lo = bus_in.data;
        ASQ_REG_CNT_HI:  next_s.cnt_hi = bus_in.data;
        default: ;
      endcase
    end
    if (rd_hit) begin
      case (bus_in.addr)
        ASQ_REG_CMD:    next_s.rd_data = 16'(s.cmd);
        ASQ_REG_SI:     next_s.rd_data = s.si;
        ASQ_REG_SCI:    next_s.rd_data = s.sci;
        ASQ_REG_CNT_LO: next_s.rd_data = s.cnt_lo;
        ASQ_REG_CNT_HI: next_s.rd_data = s.cnt_hi;
        ASQ_REG_STATUS: next_s.rd_data = 16'(st);
        ASQ_REG_FIFO:   next_s.rd_data = fifo_mem[s.f_rd];
        ASQ_REG_ENTRY:  next_s.rd_data = s.cfg_word;
        default:        next_s.rd_data = 16'h0000;
      endcase
    end
    if (cfg_load) begin
      next_s.ptr      = '0;
      next_s.cfg_word = cfg_first;
    end
    // fifo: a push that meets a clear is dropped, the fifo ends empty
    if (acq_clr) begin
      next_s.overflow = 1'b0;
      next_s.overrun  = 1'b0;
      next_s.complete = 1'b0;
      next_s.request  = 1'b0;
      next_s.f_wr     = '0;
      next_s.f_rd     = '0;
      next_s.f_cnt    = '0;
    end else begin
      if (push_ok) begin
        next_s.f_wr = s.f_wr + 1'b1;
      end
      if (pop) begin
        next_s.f_rd = s.f_rd + 1'b1;
      end
      next_s.f_cnt = s.f_cnt + (FP + 1)'(push_ok) - (FP + 1)'(pop);
    end
    if (push && !push_ok) begin
      next_s.overflow = 1'b1;
    end
    next_s.busy = conv_req || (s.busy && !adc_done_in);
    if (conv_req && s.busy) begin
      next_s.overrun = 1'b1;
    end
    // sample interval timing runs only inside a pass
    if (s.phase == ASQ_RUN && !s.cmd.ext_timing) begin
      next_s.si_cnt = s.si_cnt == 16'h0000 ? interval_reload(s.si) :
                      s.si_cnt - ASQ_ONE;
    end
    // the scan interval counter stops at its terminal count
    if (s.phase != ASQ_IDLE && s.sci_cnt != 16'h0000) begin
      next_s.sci_cnt = s.sci_cnt - ASQ_ONE;
    end
    if (conv_req) begin
      next_s.conv     = 1'b1;
      next_s.cfg_word = cfg_mem[s.ptr];
      if (s.counting) begin
        next_s.remaining = s.remaining - ASQ_LAST_COUNT;
      end
    end
    // a load strobe wins over a step that falls in the same cycle
    if (advance && !cfg_load) begin
      next_s.ptr = wrap ? '0 : s.ptr + 1'b1;
    end
    if (wrap && s.phase == ASQ_RUN && s.cmd.scan_interval_enable_bit) begin
      next_s.phase = ASQ_WAIT;
    end
    if (s.phase != ASQ_IDLE && (sw_start || trig_fall)) begin
      next_s.counting = 1'b1;
    end
    case (s.phase)
      ASQ_IDLE: begin
        if (start_run) begin
          next_s.phase     = ASQ_RUN;
          next_s.ptr       = '0;
          next_s.cfg_word  = cfg_first;
          next_s.si_cnt    = interval_reload(s.si);
          next_s.sci_cnt   = interval_reload(s.sci);
          next_s.remaining = count_load;
          next_s.counting  = !s.cmd.pretrigger;
        end
      end
      ASQ_WAIT: begin
        if (s.sci_cnt == 16'h0000) begin
          next_s.phase   = ASQ_RUN;
          next_s.sci_cnt = interval_reload(s.sci);
          next_s.si_cnt  = interval_reload(s.si);
        end
      end
      ASQ_RUN: ;
      default: next_s.phase = ASQ_IDLE;
    endcase
    // dropping the enable abandons the run without raising complete, unless the last counted conversion falls in that cycle
    if (s.phase != ASQ_IDLE && !s.cmd.acquisition_enable_bit) begin
      next_s.phase = ASQ_IDLE;
    end
    if (finish) begin
      next_s.phase    = ASQ_IDLE;
      next_s.counting = 1'b0;
      next_s.complete = 1'b1;
      next_s.request  = 1'b1;
    end
    // running is kept in its own flop so that the pin comes straight from a register
    next_s.running = next_s.phase != ASQ_IDLE;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s        <= '0;
      s.cmd    <= asq_cmd_t'(ASQ_CMD_RESET);
      s.si     <= ASQ_INTERVAL_RESET;
      s.sci    <= ASQ_INTERVAL_RESET;
      s.cnt_lo <= ASQ_COUNT_RESET;
      s.cnt_hi <= ASQ_COUNT_RESET;
      s.ext_q  <= 1'b1;
      s.trig_q <= 1'b1;
      s.c1_q   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // memories carry no reset; software clears the walk before use
  always_ff @(posedge clk_in) begin
    if (cfg_we) begin
      cfg_mem[s.cfg_wr] <= bus_in.data;
    end
    if (push_ok) begin
      fifo_mem[s.f_wr] <= adc_data_in;
    end
  end

  assign rd_data_out       = s.rd_data;
  assign conv_start_out    = s.conv;
  assign active_config_out = s.cfg_word;
  assign acq_running_out   = s.running;
  assign acq_request_out   = s.request;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_wait_done;
    s.phase == ASQ_WAIT && s.sci_cnt == 16'h0000 && s.cmd.acquisition_enable_bit;
  endsequence
  sequence s_pass_restart;
    s.phase == ASQ_RUN && s.sci_cnt == interval_reload(s.sci);
  endsequence

  property p_single_entry;
    s.phase != ASQ_IDLE && !scan_mode && !cfg_load |=> $stable(s.ptr);
  endproperty
  a_single_entry: assert property (p_single_entry) else $error("entry moved without scan");

  property p_wait_blocks;
    s.phase == ASQ_WAIT && s.sci_cnt != 16'h0000 |=> !s.conv;
  endproperty
  a_wait_blocks: assert property (p_wait_blocks) else $error("conversion during wait");

  property p_pass_restart;
    s_wait_done and !finish |=> s_pass_restart;
  endproperty
  a_pass_restart: assert property (p_pass_restart) else $error("pass did not restart");

  property p_clear_flags;
    acq_clr && !conv_req && !finish |=>
      !s.overflow && !s.overrun && !s.complete && s.f_cnt == '0 && !s.request;
  endproperty
  a_clear_flags: assert property (p_clear_flags) else $error("clear left flags");

  property p_load_first;
    cfg_load && !conv_req |=> s.ptr == '0 && s.cfg_word == $past(cfg_first);
  endproperty
  a_load_first: assert property (p_load_first) else $error("load did not apply entry");

  property p_step;
    advance && !wrap && !cfg_load |=> s.ptr == $past(s.ptr) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("entry did not step");

  property p_wrap;
    wrap |=> s.ptr == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("end of list did not wrap");

  property p_divide_hold;
    scan_mode && s.cmd.scan_divide_bit && !c1_fall && !cfg_load && !start_run
      |=> $stable(s.ptr);
  endproperty
  a_divide_hold: assert property (p_divide_hold) else $error("step without counter one");

  property p_count_stop;
    finish |=> s.phase == ASQ_IDLE && s.complete ##1 !s.conv;
  endproperty
  a_count_stop: assert property (p_count_stop) else $error("run did not stop");

  property p_overflow;
    push && s.f_cnt == F_FULL |=> s.overflow [*2];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not held");

  property p_overrun;
    conv_req && s.busy |=> s.overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
endmodule
`default_nettype wire

/* asq_pkg.sv */
// shared constants and carrier types of the acquisition scan sequencer
package asq_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ASQ_REG_CMD      = 8'h00;
  localparam logic [7:0] ASQ_REG_CFG_WIN  = 8'h04;
  localparam logic [7:0] ASQ_REG_CFG_LOAD = 8'h08;
  localparam logic [7:0] ASQ_REG_CFG_CLR  = 8'h0c;
  localparam logic [7:0] ASQ_REG_ACQ_CLR  = 8'h10;
  localparam logic [7:0] ASQ_REG_START    = 8'h14;
  localparam logic [7:0] ASQ_REG_SI       = 8'h18;
  localparam logic [7:0] ASQ_REG_SCI      = 8'h1c;
  localparam logic [7:0] ASQ_REG_CNT_LO   = 8'h20;
  localparam logic [7:0] ASQ_REG_CNT_HI   = 8'h24;
  localparam logic [7:0] ASQ_REG_STATUS   = 8'h28;
  localparam logic [7:0] ASQ_REG_FIFO     = 8'h2c;
  localparam logic [7:0] ASQ_REG_ENTRY    = 8'h30;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int          ASQ_EOL_BIT        = 15;
  localparam logic [15:0] ASQ_CMD_RESET      = 16'h0000;
  localparam logic [15:0] ASQ_INTERVAL_RESET = 16'h0002;
  localparam logic [15:0] ASQ_COUNT_RESET    = 16'h0000;
  localparam logic [15:0] ASQ_ONE            = 16'h0001;
  localparam logic [31:0] ASQ_FULL_COUNT     = 32'h0001_0000;
  localparam logic [31:0] ASQ_LAST_COUNT     = 32'h0000_0001;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] spare;
    logic       ext_timing;
    logic       pretrigger;
    logic       cascade_count_select;
    logic       scan_divide_bit;
    logic       scan_interval_enable_bit;
    logic       scan_enable_bit;
    logic       acquisition_enable_bit;
  } asq_cmd_t;
  typedef struct packed {
    logic [10:0] spare;
    logic        running;
    logic        adc_fifo_not_empty_flag;
    logic        acquisition_complete_flag;
    logic        overrun;
    logic        overflow;
  } asq_status_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
    logic        wr;
    logic        rd;
  } asq_bus_t;
  typedef enum logic [1:0] {ASQ_IDLE, ASQ_RUN, ASQ_WAIT} asq_phase_t;
endpackage

/* asq_adc_model.sv */
// converter model standing on the far side of the sequencer
`timescale 1ns/10ps
`default_nettype none
module asq_adc_model (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        conv_start_in,
  input  wire logic [15:0] config_in,
  input  wire logic [7:0]  latency_in,
  output logic [15:0]      adc_data_out,
  output logic             adc_done_out
);
  logic [7:0]  left;
  logic [15:0] word;
  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  // a start while still converting is dropped, as a real converter would
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      left <= 8'h00;
      word <= 16'h0000;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end else if (conv_start_in) begin
      left <= latency_in;
      word <= config_in;
    end
  end
  assign adc_done_out = (left == 8'h01);
  // outside the result cycle the bus shows the inverse, never a stale copy
  assign adc_data_out = adc_done_out ? word : ~word;
endmodule
`default_nettype wire

/* asq_sequencer_bench.sv */
// self-checking bench of the acquisition scan sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module asq_sequencer_bench
  import asq_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  asq_bus_t    bus = '0;
  logic [15:0] rd_data;
  logic [15:0] adc_data;
  logic [15:0] active_cfg;
  logic        adc_done;
  logic        ext_n = 1'b1;
  logic        trig_n = 1'b1;
  logic        c1_n = 1'b1;
  logic        conv_start;
  logic        running;
  logic        request;
  logic [7:0]  lat = 8'h02;
  logic [15:0] seen[$];
  int          at[$];
  int          cyc = 0;
  int          fails = 0;
  int          comparisons = 0;

  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (conv_start === 1'b1) begin
      seen.push_back(active_cfg);
      at.push_back(cyc);
    end
  end

  // fifo kept tiny so that overflow is reached in a short run
  asq_sequencer #(.CFG_DEPTH(16), .FIFO_DEPTH(4)) dut_u (
    .clk_in(clk_in), .reset_in(reset_in), .bus_in(bus), .rd_data_out(rd_data),
    .adc_data_in(adc_data), .adc_done_in(adc_done),
    .external_conversion_strobe_n_in(ext_n), .external_trigger_n_in(trig_n),
    .counter_one_output_n_in(c1_n), .conv_start_out(conv_start),
    .active_config_out(active_cfg), .acq_running_out(running),
    .acq_request_out(request));
  asq_adc_model adc_u (
    .clk_in(clk_in), .reset_in(reset_in), .conv_start_in(conv_start),
    .config_in(active_cfg), .latency_in(lat), .adc_data_out(adc_data),
    .adc_done_out(adc_done));

  // ----------------------------------------------------------------
  // bus and helper tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, data: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_in);
    bus <= '{addr: a, data: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 `CHK(nm, e, rd_data)
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      #1 n++;
    end while (running !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      fails++;
      conclude();
    end
    repeat (20) @(posedge clk_in);
  endtask
  function automatic logic [15:0] ent(int i, int n);
    return (16'h0a10 + 16'(i)) | ((i == n - 1) ? 16'h8000 : 16'h0000);
  endfunction
  task automatic load(int n);
    wr(ASQ_REG_CFG_CLR, 16'h0000);
    for (int i = 0; i < n; i++) wr(ASQ_REG_CFG_WIN, ent(i, n));
    wr(ASQ_REG_CFG_LOAD, 16'h0000);
    #1 `CHK("load entry", ent(0, n), active_cfg)
  endtask
  task automatic go(logic [15:0] cmd, logic [15:0] si, logic [15:0] cnt, bit hw);
    wr(ASQ_REG_ACQ_CLR, 16'h0000);
    wr(ASQ_REG_CMD, cmd);
    wr(ASQ_REG_SI, si);
    wr(ASQ_REG_CNT_LO, cnt);
    seen.delete();
    at.delete();
    if (hw) begin
      @(posedge clk_in) trig_n <= 1'b0;
      @(posedge clk_in) trig_n <= 1'b1;
    end else
      wr(ASQ_REG_START, 16'h0000);
  endtask
  task automatic chk_seq(string nm, int n, int ne, int div);
    `CHK(nm, n, seen.size())
    for (int i = 0; i < n && i < seen.size(); i++)
      `CHK(nm, div == 0 ? ent(0, ne) : ent((i / div) % ne, ne), seen[i])
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    chk_rd("cmd", ASQ_REG_CMD, ASQ_CMD_RESET);
    chk_rd("si", ASQ_REG_SI, ASQ_INTERVAL_RESET);
    chk_rd("sci", ASQ_REG_SCI, ASQ_INTERVAL_RESET);
    chk_rd("cnt", ASQ_REG_CNT_LO, ASQ_COUNT_RESET);
    chk_rd("status", ASQ_REG_STATUS, 16'h0000);
    chk_rd("unmapped", 8'h3c, 16'h0000);
    wr(ASQ_REG_ACQ_CLR, 16'hffff);
    chk_rd("strobe", ASQ_REG_ACQ_CLR, 16'h0000);
  endtask
  task automatic s_scan();
    load(3);
    go(16'h0003, 16'h0006, 16'h0005, 0);
    wait_idle();
    chk_seq("scan walk", 5, 3, 1);
    `CHK("sample gap", 6, at[1] - at[0])
    chk_rd("status", ASQ_REG_STATUS, 16'h000d);
    `CHK("request", 1'b1, request)
    chk_rd("fifo head", ASQ_REG_FIFO, ent(0, 3));
    wr(ASQ_REG_ACQ_CLR, 16'h0000);
    #1 `CHK("request", 1'b0, request)
    chk_rd("status", ASQ_REG_STATUS, 16'h0000);
  endtask
  task automatic s_count();
    wr(ASQ_REG_CNT_HI, 16'h0000);
    go(16'h0013, 16'h0006, 16'h0003, 0);
    wait_idle();
    chk_seq("cascade", 3, 3, 1);
    wr(ASQ_REG_CNT_HI, 16'h0001);
    go(16'h0001, 16'h0006, 16'h0002, 0);
    wait_idle();
    chk_seq("single", 2, 3, 0);
  endtask
  task automatic pulse_ext(int k);
    repeat (k) begin
      @(posedge clk_in) ext_n <= 1'b0;
      @(posedge clk_in) ext_n <= 1'b1;
      repeat (8) @(posedge clk_in);
    end
  endtask
  task automatic s_ext();
    wr(ASQ_REG_CMD, 16'h0041);
    seen.delete();
    pulse_ext(2);
    `CHK("early edges", 0, seen.size())
    go(16'h0041, 16'h0006, 16'h0002, 0);
    pulse_ext(3);
    wait_idle();
    chk_seq("ext", 2, 3, 0);
  endtask
  task automatic s_div();
    load(2);
    go(16'h000b, 16'h000a, 16'h0004, 0);
    for (int n = 0; seen.size() < 2 && n < 300; n++) @(posedge clk_in);
    if (seen.size() < 2) begin
      fails++;
      conclude();
    end
    @(posedge clk_in) c1_n <= 1'b0;
    @(posedge clk_in) c1_n <= 1'b1;
    wait_idle();
    chk_seq("divide", 4, 2, 2);
  endtask
  task automatic s_interval();
    int g1;
    int g2;
    wr(ASQ_REG_SCI, 16'h001e);
    go(16'h0007, 16'h0006, 16'h0006, 1);
    wait_idle();
    chk_seq("interval", 6, 2, 1);
    g1 = at[2] - at[0];
    g2 = at[4] - at[2];
    `CHK("pass gap", 1'b1, g1 >= 29 && g1 <= 31)
    `CHK("pass gap", g1, g2)
  endtask
  task automatic s_slow();
    int n;
    @(posedge clk_in) lat <= 8'h0c;
    go(16'h0001, 16'h0006, 16'h0003, 0);
    wait_idle();
    chk_rd("overrun", ASQ_REG_STATUS, 16'h000e);
    @(posedge clk_in) lat <= 8'h02;
    go(16'h0021, 16'h0006, 16'h0002, 0);
    repeat (40) @(posedge clk_in);
    #1 `CHK("pre running", 1'b1, running)
    wr(ASQ_REG_START, 16'h0000);
    #1 n = seen.size();
    wait_idle();
    `CHK("pre counted", 1'b1, seen.size() - n inside {2, 3})
  endtask

  initial begin
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    s_reset();
    s_scan();
    s_count();
    s_ext();
    s_div();
    s_interval();
    s_slow();
    conclude();
  end
endmodule
`default_nettype wire
